// File: dv/eeprom_model.sv
`timescale 1ns/10ps
`default_nettype none
module eeprom_model (
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic clr_i,
    input wire logic rd_mode_i,
    input wire logic ack_i,
    input wire logic [7:0] rd_byte_i,
    output logic sda_oe_o,
    output logic [7:0] wbyte_o,
    output logic mst_ack_o
);
    logic [3:0] rises;
    logic [3:0] slot;
    // rises counted, data moved only while the clock is low
    always @(posedge scl_i or posedge clr_i) begin
        if (clr_i) begin
            rises <= 4'h0;
        end else begin
            if (rises < 4'h8) wbyte_o <= {wbyte_o[6:0], sda_i};
            if (rises == 4'h8) mst_ack_o <= sda_i;
            if (rises < 4'h9) rises <= rises + 4'h1;
        end
    end
    always @(negedge scl_i or posedge clr_i) begin
        if (clr_i) begin
            slot <= 4'h0;
        end else begin
            slot <= rises;
        end
    end
    // released outside its slots, so the pull-up wins
    assign sda_oe_o = rd_mode_i
        ? (slot < 4'h8 && !rd_byte_i[3'h7 - slot[2:0]])
        : (slot == 4'h8 && ack_i);
endmodule
`default_nettype wire

// File: dv/eeprom_serial_command_master_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module eeprom_serial_command_master_asserts
    import eeprom_master_pkg::*;
#(
    parameter int unsigned quarter = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic data_wr_i,
    input wire logic [7:0] data_wdata_i,
    input wire logic [7:0] eeprom_byte_buffer_o,
    input wire logic cmd_wr_i,
    input wire logic [7:0] cmd_wdata_i,
    input wire logic [7:0] eeprom_command_status_o,
    input wire logic transfer_done_interrupt_o,
    input wire logic [7:0] rx_data_o,
    input wire logic rx_valid_o,
    input wire logic rx_ready_i,
    input wire bus_drive_t pins_o,
    input wire logic sda_i,
    input wire logic scl_i
);
    wire busy = eeprom_command_status_o[bit_busy];
    wire [3:0] c = cmd_wdata_i[3:0];
    wire legal = c inside {4'h0, 4'h2, 4'h3, 4'h5, 4'h6, 4'h9};
    wire go = cmd_wr_i && !busy;
    wire irq = transfer_done_interrupt_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_busy_set: assert property (go && legal && c != 4'h0 |=> busy)
        else $error("busy not raised after command");
    a_err_set: assert property (cmd_wr_i && !legal
        |=> eeprom_command_status_o[7])
        else $error("error flag not set");
    a_err_idle: assert property (go && !legal |=> !busy)
        else $error("illegal command started the bus");
    a_done_irq: assert property ($fell(busy) |-> ##[0:1] irq)
        else $error("no completion pulse");
    a_irq_single: assert property (irq |=> !irq)
        else $error("completion pulse too long");
    a_open_drain: assert property (!pins_o.scl_o && !pins_o.sda_o)
        else $error("line driven high");
    a_start_edge: assert property ($rose(pins_o.sda_oe) && !pins_o.scl_oe
        && $stable(pins_o.scl_oe) |-> busy)
        else $error("data fell under high clock while idle");
    a_stop_edge: assert property ($fell(pins_o.sda_oe) && !pins_o.scl_oe
        && $stable(pins_o.scl_oe) |-> busy)
        else $error("data rose under high clock while idle");
    a_busy_hold: assert property ($rose(busy) |-> busy [*8])
        else $error("busy too short");
    a_noop_quiet: assert property (go && c == 4'h0 |->
        ##[1:600] !pins_o.scl_oe [*8])
        else $error("clock still toggling after no-op");
    c_tx: cover property (go && c == 4'h3);
    c_rx: cover property (rx_valid_o && rx_ready_i);
    c_done: cover property (irq);
endmodule
bind eeprom_serial_command_master eeprom_serial_command_master_asserts
    #(.quarter(quarter)) i_chk (.clk_i(clk_i), .rst_i(rst_i),
    .data_wr_i(data_wr_i), .data_wdata_i(data_wdata_i),
    .eeprom_byte_buffer_o(eeprom_byte_buffer_o), .cmd_wr_i(cmd_wr_i),
    .cmd_wdata_i(cmd_wdata_i),
    .eeprom_command_status_o(eeprom_command_status_o),
    .transfer_done_interrupt_o(transfer_done_interrupt_o),
    .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
    .pins_o(pins_o), .sda_i(sda_i), .scl_i(scl_i));
`default_nettype wire

// File: dv/eeprom_serial_command_master_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
    $display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module eeprom_serial_command_master_test;
    import eeprom_master_pkg::*;
    logic clk_i = 0, rst_i = 1, dwr = 0, cwr = 0, rdy = 0, g = 0;
    logic rd_mode = 0, ack = 0, clr = 0, irq, rxv, m_oe, m_ack;
    logic [7:0] wd = 0, cd = 0, rb = 0, buf_q, st, rxd, wbyte;
    bus_drive_t pins;
    logic [7:0] q[$];
    int num_errors = 0, n_compared = 0;
    wire scl = !pins.scl_oe;
    wire sda = !(pins.sda_oe || m_oe);
    always #12.5 clk_i = ~clk_i;
    eeprom_serial_command_master #(.quarter(4)) i_dut (.clk_i(clk_i),
        .rst_i(rst_i), .data_wr_i(dwr), .data_wdata_i(wd),
        .eeprom_byte_buffer_o(buf_q), .cmd_wr_i(cwr), .cmd_wdata_i(cd),
        .eeprom_command_status_o(st), .transfer_done_interrupt_o(irq),
        .rx_data_o(rxd), .rx_valid_o(rxv), .rx_ready_i(rdy),
        .pins_o(pins), .sda_i(sda), .scl_i(scl));
    eeprom_model i_eeprom (.scl_i(scl), .sda_i(sda), .clr_i(clr),
        .rd_mode_i(rd_mode), .ack_i(ack), .rd_byte_i(rb), .sda_oe_o(m_oe),
        .wbyte_o(wbyte), .mst_ack_o(m_ack));
    task step; @(posedge clk_i); #1; endtask
    task final_report;
        if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic op(input logic [3:0] c);
        int i;
        step(); cwr = 1; cd = {4'h0, c};
        step(); cwr = 0; clr = 0; g = 0;
        if (c inside {4'h2, 4'h3, 4'h5, 4'h6, 4'h9}) `CHK(st[6], 1'b1)
        for (i = 0; i < 3000 && st[bit_busy] !== 1'b0; i++) begin
            step(); g |= irq;
        end
        step(); g |= irq;
        if (i == 3000) begin num_errors++; final_report(); end
    endtask
    task automatic byte_op(input logic [3:0] c, input logic [7:0] b);
        rd_mode = (c != cmd_tx); rb = b; wd = b; dwr = 1; clr = 1;
        step(); dwr = 0;
        op(c);
        `CHK(g, 1'b1)
        if (rd_mode) q.push_back(b);
    endtask
    task t_noop;
        op(cmd_noop); repeat (16) step();
        `CHK(scl, 1'b1)
    endtask
    task t_tx;
        op(cmd_start); `CHK(sda, 1'b0)
        ack = 1; byte_op(cmd_tx, 8'ha5); `CHK(wbyte, 8'ha5)
        `CHK(st[bit_rx_ack_n], 1'b0)
        ack = 0; byte_op(cmd_tx, 8'h5a); `CHK(st[bit_rx_ack_n], 1'b1)
        t_noop();
    endtask
    task t_rx;
        byte_op(cmd_rx_ack, 8'h3c); `CHK(buf_q, 8'h3c)
        `CHK(m_ack, 1'b0)
        `CHK(st[bit_tx_ack_n], 1'b0)
        byte_op(cmd_rx_last, 8'hc3); `CHK(m_ack, 1'b1)
        op(cmd_stop); `CHK(sda, 1'b1)
        t_noop();
    endtask
    task t_illegal;
        for (int c = 1; c < 16; c++) if (!(c inside {2, 3, 5, 6, 9})) begin
            op(c[3:0]); `CHK({st[7:6], g}, 3'b100)
        end
    endtask
    task t_fifo;
        for (int i = 0; i < 6; i++) byte_op(cmd_rx_ack, 8'h50 + 8'(i));
        t_noop();
        while (q.size() > 0) begin
            `CHK({rxv, rxd}, {1'b1, q.pop_front()})
            rdy = 1; step(); rdy = 0;
        end
        `CHK(rxv, 1'b0)
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        #1 rst_i = 0;
        `CHK(st, status_reset)
        `CHK(buf_q, 8'h00)
        t_tx(); t_rx(); t_illegal(); t_fifo();
        final_report();
    end
endmodule
`default_nettype wire

// File: hdl/byte_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module byte_fifo #(
    parameter int unsigned width = 8,
    parameter int unsigned depth = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [width-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [width-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int unsigned aw = $clog2(depth);
    logic [width-1:0] mem [depth];
    logic [aw:0] wr_q, rd_q;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;
    assign in_ready_o = (wr_q - rd_q) != (aw+1)'(depth);
    assign out_valid_o = wr_q != rd_q;
    assign out_data_o = mem[rd_q[aw-1:0]];
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_q[aw-1:0]] <= in_data_i;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: hdl/eeprom_master_pkg.sv
// Summary of operation
// - sole master, no stretching, no arbitration
// - bit 7 error on illegal command, cleared by next launch
// - bit 6 busy while bus operation runs
// - bit 5 low when eeprom acknowledged
// - bit 4 low once master sent ack
// - code 0 no-op stops serial clock
// - code 2 receive byte then send ack
// - code 3 send data byte, sample ack
// - code 5 stop: data rises, clock high
// - code 6 receive last byte, send nack
// - code 9 start: data falls, clock high
// - other codes: no activity, set error
// - data first, command write launches operation
// - busy falling pulses completion interrupt
// - serial clock about 78 kHz
package eeprom_master_pkg;
    localparam int unsigned clk_hz = 40000000;
    localparam int unsigned scl_hz = 78000;
    // quarter bit period enable
    localparam int unsigned quarter_cycles = clk_hz / (scl_hz * 4);
    localparam int unsigned div_w = 8;
    localparam logic [3:0] cmd_noop = 4'h0;
    localparam logic [3:0] cmd_rx_ack = 4'h2;
    localparam logic [3:0] cmd_tx = 4'h3;
    localparam logic [3:0] cmd_stop = 4'h5;
    localparam logic [3:0] cmd_rx_last = 4'h6;
    localparam logic [3:0] cmd_start = 4'h9;
    localparam int unsigned bit_error = 7;
    localparam int unsigned bit_busy = 6;
    localparam int unsigned bit_rx_ack_n = 5;
    localparam int unsigned bit_tx_ack_n = 4;
    localparam logic [7:0] status_reset = 8'h30;
    localparam int unsigned fifo_depth = 8;

    typedef struct packed {
        logic sda_o;
        logic sda_oe;
        logic scl_o;
        logic scl_oe;
    } bus_drive_t;
endpackage

// File: hdl/eeprom_serial_command_master.sv
`timescale 1ns/10ps
`default_nettype none
module eeprom_serial_command_master #(
    parameter int unsigned quarter = eeprom_master_pkg::quarter_cycles
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // processor side: data register and command/status register
    input wire logic data_wr_i,
    input wire logic [7:0] data_wdata_i,
    output logic [7:0] eeprom_byte_buffer_o,
    input wire logic cmd_wr_i,
    input wire logic [7:0] cmd_wdata_i,
    output logic [7:0] eeprom_command_status_o,
    output logic transfer_done_interrupt_o,
    // received bytes stream
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    // two-wire bus pins
    output eeprom_master_pkg::bus_drive_t pins_o,
    input wire logic sda_i,
    input wire logic scl_i
);
    import eeprom_master_pkg::*;

    typedef enum logic [2:0] {
        st_idle, st_start, st_stop, st_bits, st_ack, st_free
    } state_t;

    ////////////////////////////////////////////////////////////////////////
    // command decoding shared by launch, error and receive paths
    // codes that start a bus operation
    function automatic logic known_code(input logic [3:0] c);
        return c == cmd_rx_ack || c == cmd_tx || c == cmd_stop
            || c == cmd_rx_last || c == cmd_start;
    endfunction

    function automatic logic receive_code(input logic [3:0] c);
        return c == cmd_rx_ack || c == cmd_rx_last;
    endfunction

    // codes that shift bits and leave the clock running afterwards
    function automatic logic clocked_code(input logic [3:0] c);
        return c != cmd_start && c != cmd_stop;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // two-stage synchronisers for the line levels
    logic sda_m_q, sda_s_q, scl_m_q, scl_s_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
        end else begin
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // quarter-bit enable divider
    logic [div_w-1:0] div_q;
    logic tick_q;
    wire div_end = div_q == div_w'(quarter - 1);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_end ? '0 : div_q + 1'b1;
            tick_q <= div_end;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command launch and bit sequencer; each bit spans four quarters:
    //   0 set data, 1 raise clock, 2 sample data, 3 drop clock
    // start and stop reuse the four steps with another data order
    state_t state_q;
    logic [1:0] phase_q;
    logic [2:0] bit_q;
    logic [7:0] shift_q, data_q;
    logic [3:0] op_q;
    logic busy_q, error_q, rx_ack_n_q, tx_ack_n_q, done_q;
    logic sda_q, scl_q, clk_run_q;
    logic push_q;
    logic fifo_ready;

    wire [3:0] code = cmd_wdata_i[3:0];
    wire code_ok = known_code(code);
    wire is_noop = code == cmd_noop;
    // no-op stops the idle clock; ignored mid-operation
    wire stop_clk = cmd_wr_i && is_noop && !busy_q;
    wire launch = cmd_wr_i && code_ok && !busy_q;
    wire illegal = cmd_wr_i && !code_ok && !is_noop;
    wire is_rx = receive_code(op_q);
    wire last_q = phase_q == 2'd3;
    // hold receive completion while the byte stream is full
    wire step = tick_q && !(state_q == st_free && is_rx && !fifo_ready);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= st_idle;
            phase_q <= '0;
            bit_q <= '0;
            shift_q <= '0;
            op_q <= cmd_noop;
            busy_q <= 1'b0;
            sda_q <= 1'b1;
            scl_q <= 1'b1;
            clk_run_q <= 1'b0;
            rx_ack_n_q <= 1'b1;
            tx_ack_n_q <= 1'b1;
            push_q <= 1'b0;
        end else begin
            push_q <= 1'b0;
            if (stop_clk) begin
                clk_run_q <= 1'b0;
                scl_q <= 1'b1;
            end
            if (launch) begin
                busy_q <= 1'b1;
                op_q <= code;
                phase_q <= '0;
                bit_q <= 3'd7;
                shift_q <= data_q;
                if (clocked_code(code)) begin
                    clk_run_q <= 1'b1;
                end
                // park the clock low so no data edge meets a high clock
                if (code != cmd_start) begin
                    scl_q <= 1'b0;
                end
                case (code)
                    cmd_start: state_q <= st_start;
                    cmd_stop: state_q <= st_stop;
                    default: state_q <= st_bits;
                endcase
            end else if (step && state_q != st_idle) begin
                phase_q <= phase_q + 2'd1;
                case (state_q)
                    st_start: begin
                        // data falls while clock high
                        case (phase_q)
                            2'd0: sda_q <= 1'b1;
                            2'd1: scl_q <= 1'b1;
                            2'd2: sda_q <= 1'b0;
                            default: scl_q <= 1'b0;
                        endcase
                        if (last_q) begin
                            state_q <= st_free;
                        end
                    end
                    st_stop: begin
                        // data rises while clock high
                        case (phase_q)
                            2'd0: sda_q <= 1'b0;
                            2'd1: scl_q <= 1'b1;
                            2'd2: sda_q <= 1'b1;
                            default: scl_q <= 1'b1;
                        endcase
                        if (last_q) begin
                            state_q <= st_free;
                        end
                    end
                    st_bits: begin
                        case (phase_q)
                            // release data on receive
                            2'd0: sda_q <= is_rx ? 1'b1 : shift_q[7];
                            2'd1: scl_q <= 1'b1;
                            2'd2: begin
                                if (is_rx) begin
                                    shift_q <= {shift_q[6:0], sda_s_q};
                                end else begin
                                    shift_q <= {shift_q[6:0], 1'b0};
                                end
                            end
                            default: scl_q <= 1'b0;
                        endcase
                        if (last_q) begin
                            bit_q <= bit_q - 3'd1;
                            if (bit_q == 3'd0) begin
                                state_q <= st_ack;
                            end
                        end
                    end
                    st_ack: begin
                        case (phase_q)
                            2'd0: begin
                                if (op_q == cmd_rx_ack) begin
                                    sda_q <= 1'b0;
                                end else begin
                                    sda_q <= 1'b1;
                                end
                            end
                            2'd1: scl_q <= 1'b1;
                            2'd2: begin
                                if (op_q == cmd_tx) begin
                                    rx_ack_n_q <= sda_s_q;
                                end
                                if (op_q == cmd_rx_ack) begin
                                    tx_ack_n_q <= 1'b0;
                                end
                            end
                            default: scl_q <= 1'b0;
                        endcase
                        if (last_q) begin
                            state_q <= st_free;
                        end
                    end
                    st_free: begin
                        phase_q <= '0;
                        state_q <= st_idle;
                        busy_q <= 1'b0;
                        push_q <= is_rx;
                    end
                    default: state_q <= st_idle;
                endcase
            end else if (tick_q && state_q == st_idle && clk_run_q
                && !stop_clk) begin
                // clock keeps toggling until a no-op arrives
                phase_q <= phase_q + 2'd1;
                if (phase_q[0]) begin
                    scl_q <= !scl_q;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_q <= '0;
            error_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            if (push_q) begin
                data_q <= shift_q;
            end else if (data_wr_i) begin
                data_q <= data_wdata_i;
            end
            if (illegal) begin
                error_q <= 1'b1;
            end else if (launch) begin
                error_q <= 1'b0;
            end
            done_q <= step && state_q == st_free;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // received bytes queue for a streaming reader
    byte_fifo #(
        .width(8),
        .depth(fifo_depth)
    ) rx_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_data_i(shift_q),
        .in_valid_i(push_q),
        .in_ready_o(fifo_ready),
        .out_data_o(rx_data_o),
        .out_valid_o(rx_valid_o),
        .out_ready_i(rx_ready_i)
    );

    ////////////////////////////////////////////////////////////////////////
    // open-drain: drive only low; clock is never stretched
    bus_drive_t pins_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pins_q <= '0;
        end else begin
            pins_q.sda_o <= 1'b0;
            pins_q.sda_oe <= !sda_q;
            pins_q.scl_o <= 1'b0;
            pins_q.scl_oe <= !scl_q;
        end
    end
    assign pins_o = pins_q;

    // status byte: command field reads back as zero
    assign eeprom_byte_buffer_o = data_q;
    assign eeprom_command_status_o = {error_q, busy_q, rx_ack_n_q,
        tx_ack_n_q, 4'h0};
    assign transfer_done_interrupt_o = done_q;

    // scl_s_q is sampled only for observability of the line
    logic scl_seen_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_seen_q <= 1'b1;
        end else begin
            scl_seen_q <= scl_s_q;
        end
    end
endmodule
`default_nettype wire
